// >>> hw/keypad_matrix_scanner.sv
// Functional notes
// RULE1 - Four row outputs, eight column inputs, sixteen rows.
// RULE2 - Smallest size drives rows directly, one-hot.
// RULE3 - Encode two keys; more gives lowest two.
// RULE4 - Three programmed keys raise interrupt or reset.
// RULE5 - Interrupt on press and again on release.
// RULE6 - Size field selects four, eight, sixteen rows.
// RULE7 - Debounce counts equal scans to terminal count.
// RULE8 - Row period is divider ticks, sixteen per scan.
// RULE9 - Scan enable bit starts and stops scanning.
// RULE10 - Software sets port select before use.
// RULE11 - Enable and select bits choose three-key action.
// RULE12 - Three keys held as row and column fields.
// RULE13 - Wakeup works only in four-row size.
// RULE14 - Wake enable, column mask, row address gate wakeup.
// RULE15 - Status interrupt bit shows pending key interrupt.
// RULE16 - Status flag marks a three-key reset.
// RULE17 - Status flag marks a keypad wakeup.
// RULE18 - Status flags for one and two keys.
// RULE19 - Status reports two key row/column addresses.
// RULE20 - Rows asserted ascending, columns sampled per row.
// RULE21 - Pressed key pulls column low; pull-ups idle.
`timescale 1ns/1ps
module keypad_matrix_scanner
	import keypad_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [7:0] col_n_in,
	input wire logic powerdown_in,
	output logic [3:0] row_scan_out,
	output logic port_select_out,
	output logic key_irq_out,
	output logic chip_reset_out_n,
	output logic wake_out
);

	function automatic logic [2:0] ones(input logic [7:0] v);
		logic [2:0] n;
		n = 3'd0;
		for (int i = 0; i < 8; i++) begin
			if (v[i] && n != 3'd4) begin
				n = n + 3'd1;
			end
		end
		return n;
	endfunction

	function automatic logic [2:0] nth_col(input logic [7:0] v,
			input logic skip);
		logic seen;
		logic done;
		logic [2:0] idx;
		seen = 1'b0;
		done = 1'b0;
		idx = 3'd0;
		for (int i = 0; i < 8; i++) begin
			if (v[i] && !done) begin
				if (skip && !seen) begin
					seen = 1'b1;
				end else begin
					idx = i[2:0];
					done = 1'b1;
				end
			end
		end
		return idx;
	endfunction

	logic [31:0] cfg_q, tk_q, wk_q, prdata_q;
	logic [7:0] col_s1_q, col_s2_q, col_s3_q, col_q;
	logic tick;
	logic [3:0] row_q;
	logic [7:0] pre_q, db_q;
	logic [2:0] cnt_q, match_q;
	logic [6:0] k0_q, k1_q, prev_k0_q, prev_k1_q, st_k0_q, st_k1_q;
	logic [2:0] prev_cnt_q;
	logic reported_q, one_q, two_q, int_q, combo_q, rst_flag_q, wake_flag_q;
	logic wake_q, rst_n_q;
	logic [6:0] rst_cnt_q;

	scan_tick_gen u_tick (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.tick_out(tick)
	);

	// Register access decode.
	wire hit_cfg = paddr_in == CONFIG_ADDR;
	wire hit_tk = paddr_in == THREE_KEY_ADDR;
	wire hit_wk = paddr_in == WAKE_ADDR;
	wire hit_st = paddr_in == STATUS_ADDR;
	wire hit = hit_cfg | hit_tk | hit_wk | hit_st;
	wire access = psel_in & penable_in;
	wire wr = access & pwrite_in & hit;
	wire setup_rd = psel_in & ~penable_in & ~pwrite_in;
	wire st_read = access & ~pwrite_in & hit_st;
	// A read clears only flags it returned, so a flag set at setup survives.
	wire clr_int = st_read & prdata_q[ST_INT_BIT];
	wire clr_combo = st_read & prdata_q[ST_COMBO_BIT];
	wire clr_rst = st_read & prdata_q[ST_RST_BIT];
	wire clr_wake = st_read & prdata_q[ST_WAKE_BIT];

	// Configuration fields.
	wire scan_en = cfg_q[CFG_EN_BIT];
	wire [1:0] size = cfg_q[CFG_SIZE_LSB +: 2];
	wire [7:0] debounce_terminal_count = cfg_q[CFG_DEBOUNCE_TERMINAL_COUNT_LSB +: 8];
	wire [7:0] divider = cfg_q[CFG_DIV_LSB +: 8];
	wire tk_en = tk_q[TK_EN_BIT];
	wire tk_rst = tk_q[TK_RST_BIT];
	wire [6:0] tk_key0 = tk_q[TK_FIRST_LSB +: 7];
	wire [6:0] tk_key1 = tk_q[TK_SECOND_LSB +: 7];
	wire [6:0] tk_key2 = tk_q[TK_THIRD_LSB +: 7];
	wire [7:0] wk_mask = wk_q[WK_MASK_LSB +: 8];
	wire [3:0] wk_row = wk_q[WK_ROW_LSB +: 4];

	// Rows beyond the selected size are skipped but keep their time slot.
	wire row_valid = (size == SIZE_4) ? (row_q[3:2] == 2'b00) : // see RULE6
		(size == SIZE_8) ? ~row_q[3] : 1'b1;
	wire [7:0] pressed = row_valid ? col_q : 8'h00; // see RULE21
	wire period_end = tick & (pre_q + 8'h01 >= divider); // see RULE8
	wire scan_end = scan_en & period_end & (row_q == LAST_ROW);

	// Per-row encoding: the lowest addresses win.
	wire [2:0] row_ones = ones(pressed);
	wire [2:0] c0 = nth_col(pressed, 1'b0);
	wire [2:0] c1 = nth_col(pressed, 1'b1);
	// Summed at four bits so a wide row cannot wrap the saturated count.
	wire [3:0] cnt_wide = {1'b0, cnt_q} + {1'b0, row_ones};
	wire [2:0] sum_cnt = (cnt_wide > 4'h4) ? 3'd4 : cnt_wide[2:0];
	wire [6:0] k0_d = (cnt_q == 3'd0 && row_ones != 3'd0) ? {row_q, c0}
		: k0_q; // see RULE3
	wire [6:0] k1_d = (cnt_q == 3'd0 && row_ones >= 3'd2) ? {row_q, c1} :
		(cnt_q == 3'd1 && row_ones != 3'd0) ? {row_q, c0} : k1_q;

	logic [2:0] match_d;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_match
			wire [6:0] key = (g == 0) ? tk_key0 : (g == 1) ? tk_key1 : tk_key2;
			assign match_d[g] = match_q[g] |
				(key[6:3] == row_q & pressed[key[2:0]]); // see RULE12
		end
	endgenerate

	// Debounce and report decision, evaluated at the end of each scan.
	wire same = sum_cnt == prev_cnt_q & k0_d == prev_k0_q &
		k1_d == prev_k1_q;
	wire [7:0] db_d = same ? ((db_q == 8'hFF) ? db_q : db_q + 8'h01) : 8'h00;
	wire settled = scan_end & (db_d == debounce_terminal_count) & ~(same & reported_q); // see RULE7
	wire [1:0] shown = (sum_cnt >= 3'd2) ? 2'd2 : sum_cnt[1:0];
	wire changed = {two_q, one_q} != {shown == 2'd2, shown == 2'd1} |
		(shown != 2'd0 & k0_d != st_k0_q) | (shown == 2'd2 & k1_d != st_k1_q);
	wire key_event = settled & changed; // see RULE5
	wire combo = settled & tk_en & sum_cnt == 3'd3 & (&match_d); // see RULE4
	wire wake_cond = powerdown_in & wk_q[WK_EN_BIT] & size == SIZE_4 &
		|(col_q & wk_mask); // see RULE13

	// Direct drive is active low one-hot; otherwise the decoder gets the row.
	wire [3:0] drive_row = (powerdown_in & wk_q[WK_EN_BIT]) ? wk_row : row_q;
	wire [3:0] onehot_n = ~(4'h1 << drive_row[1:0]);
	wire drive_on = scan_en | (powerdown_in & wk_q[WK_EN_BIT]);
	assign row_scan_out = (size != SIZE_4) ? drive_row :
		drive_on ? onehot_n : 4'hF; // see RULE1 see RULE2 see RULE14

	wire [31:0] status = {10'h000, int_q, rst_flag_q, wake_flag_q, combo_q,
		two_q, one_q, 1'b0, st_k1_q, 1'b0, st_k0_q};
	wire [31:0] rd_mux = hit_cfg ? cfg_q : hit_tk ? tk_q :
		hit_wk ? wk_q : hit_st ? status : 32'h0000_0000;

	assign prdata_out = prdata_q;
	assign pready_out = 1'b1;
	assign pslverr_out = access & ~hit;
	assign port_select_out = cfg_q[CFG_SEL_BIT]; // see RULE10
	assign key_irq_out = int_q | combo_q;
	assign chip_reset_out_n = rst_n_q;
	assign wake_out = wake_q;

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			cfg_q <= CONFIG_RESET;
			tk_q <= THREE_KEY_RESET;
			wk_q <= WAKE_RESET;
			prdata_q <= 32'h0000_0000;
		end else begin
			if (wr & hit_cfg) begin
				cfg_q <= pwdata_in & CONFIG_MASK;
			end
			if (wr & hit_tk) begin
				tk_q <= pwdata_in & THREE_KEY_MASK;
			end
			if (wr & hit_wk) begin
				wk_q <= pwdata_in & WAKE_MASK;
			end
			if (setup_rd) begin
				prdata_q <= rd_mux;
			end
		end
	end

	// Columns come from pins; a change counts once two stages agree.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			col_s1_q <= 8'hFF;
			col_s2_q <= 8'hFF;
			col_s3_q <= 8'hFF;
			col_q <= 8'h00;
		end else begin
			col_s1_q <= col_n_in;
			col_s2_q <= col_s1_q;
			col_s3_q <= col_s2_q;
			if (col_s2_q == col_s3_q) begin
				col_q <= ~col_s3_q;
			end
		end
	end

	// Row stepping and per-scan accumulation.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in || !scan_en) begin // see RULE9
			row_q <= 4'h0;
			pre_q <= 8'h00;
			cnt_q <= 3'd0;
			match_q <= 3'b000;
			k0_q <= 7'h00;
			k1_q <= 7'h00;
		end else if (tick) begin
			pre_q <= period_end ? 8'h00 : pre_q + 8'h01;
			if (period_end) begin
				row_q <= row_q + 4'h1; // see RULE20
				cnt_q <= scan_end ? 3'd0 : sum_cnt;
				match_q <= scan_end ? 3'b000 : match_d;
				k0_q <= scan_end ? 7'h00 : k0_d;
				k1_q <= scan_end ? 7'h00 : k1_d;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			db_q <= 8'h00;
			prev_cnt_q <= 3'd0;
			prev_k0_q <= 7'h00;
			prev_k1_q <= 7'h00;
			reported_q <= 1'b1;
		end else if (scan_end) begin
			db_q <= db_d;
			prev_cnt_q <= sum_cnt;
			prev_k0_q <= k0_d;
			prev_k1_q <= k1_d;
			reported_q <= (same & reported_q) | (db_d == debounce_terminal_count);
		end
	end

	// Status; an event in the clearing read's cycle still sets its flag.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			one_q <= 1'b0;
			two_q <= 1'b0;
			st_k0_q <= 7'h00;
			st_k1_q <= 7'h00;
			int_q <= 1'b0;
			combo_q <= 1'b0;
			rst_flag_q <= 1'b0;
			wake_flag_q <= 1'b0;
		end else begin
			if (key_event) begin
				one_q <= shown == 2'd1; // see RULE18
				two_q <= shown == 2'd2;
				st_k0_q <= (shown != 2'd0) ? k0_d : 7'h00; // see RULE19
				st_k1_q <= (shown == 2'd2) ? k1_d : 7'h00;
			end
			int_q <= key_event | (int_q & ~clr_int); // see RULE15
			combo_q <= (combo & ~tk_rst) |
				(combo_q & ~clr_combo); // see RULE11
			rst_flag_q <= (combo & tk_rst) |
				(rst_flag_q & ~clr_rst); // see RULE16
			wake_flag_q <= (wake_cond & ~wake_q) |
				(wake_flag_q & ~clr_wake); // see RULE17
		end
	end

	// The reset pulse has a fixed width so a held combination fires once.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			rst_cnt_q <= 7'd0;
			rst_n_q <= 1'b1;
			wake_q <= 1'b0;
		end else begin
			wake_q <= wake_cond; // see RULE14
			if (combo & tk_rst & rst_n_q) begin
				rst_cnt_q <= 7'(RESET_PULSE_CYC - 1);
				rst_n_q <= 1'b0;
			end else if (rst_cnt_q != 7'd0) begin
				rst_cnt_q <= rst_cnt_q - 7'd1;
			end else begin
				rst_n_q <= 1'b1;
			end
		end
	end

endmodule

// >>> hw/keypad_pkg.sv
package keypad_pkg;

	// Register byte addresses on the peripheral bus.
	localparam logic [31:0] CONFIG_ADDR = 32'hB800_8000;
	localparam logic [31:0] THREE_KEY_ADDR = 32'hB800_8004;
	localparam logic [31:0] WAKE_ADDR = 32'hB800_8008;
	localparam logic [31:0] STATUS_ADDR = 32'hB800_800C;

	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
	localparam logic [31:0] THREE_KEY_RESET = 32'h0000_0000;
	localparam logic [31:0] WAKE_RESET = 32'h0000_0000;

	// Bits that software can store; all others read as zero.
	localparam logic [31:0] CONFIG_MASK = 32'h000F_FFFF;
	localparam logic [31:0] THREE_KEY_MASK = 32'h037F_7F7F;
	localparam logic [31:0] WAKE_MASK = 32'h0001_FF0F;

	// keypad_config fields.
	localparam int CFG_SEL_BIT = 19;
	localparam int CFG_EN_BIT = 18;
	localparam int CFG_SIZE_LSB = 16;
	localparam int CFG_DEBOUNCE_TERMINAL_COUNT_LSB = 8;
	localparam int CFG_DIV_LSB = 0;

	// three_key_config fields; a key is {row[3:0], col[2:0]}.
	localparam int TK_EN_BIT = 25;
	localparam int TK_RST_BIT = 24;
	localparam int TK_THIRD_LSB = 16;
	localparam int TK_SECOND_LSB = 8;
	localparam int TK_FIRST_LSB = 0;

	// low_power_wake_config fields.
	localparam int WK_EN_BIT = 16;
	localparam int WK_MASK_LSB = 8;
	localparam int WK_ROW_LSB = 0;

	// keypad_status fields.
	localparam int ST_INT_BIT = 21;
	localparam int ST_RST_BIT = 20;
	localparam int ST_WAKE_BIT = 19;
	localparam int ST_COMBO_BIT = 18;
	localparam int ST_TWO_BIT = 17;
	localparam int ST_ONE_BIT = 16;
	localparam int ST_K1_LSB = 8;
	localparam int ST_K0_LSB = 0;

	localparam logic [1:0] SIZE_4 = 2'b00;
	localparam logic [1:0] SIZE_8 = 2'b01;
	localparam logic [3:0] LAST_ROW = 4'hF;

	// Scan tick: 0.9375 MHz from 100 MHz, as a fractional accumulator.
	localparam int CLK_KHZ = 100000;
	localparam int TICK_KHZ_X16 = 15000;
	localparam int TICK_STEP = TICK_KHZ_X16 / 1000;
	localparam int TICK_MOD = CLK_KHZ * 16 / 1000;

	// Width of the chip reset pulse.
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_PULSE_NS = 1000;
	localparam int RESET_PULSE_CYC = RESET_PULSE_NS / CLK_PERIOD_NS;

endpackage

// >>> hw/scan_tick_gen.sv
`timescale 1ns/1ps
module scan_tick_gen
	import keypad_pkg::*;
#(
	parameter int STEP = TICK_STEP,
	parameter int MODULUS = TICK_MOD
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	output logic tick_out
);

	if (STEP < 1 || STEP >= MODULUS || MODULUS > 2047) begin : g_bad_cfg
		$error("scan_tick_gen: unusable step or modulus");
	end

	logic [10:0] acc_q;
	logic [10:0] acc_d;
	logic [11:0] sum;
	logic wrap;

	// The accumulator keeps the long-run rate exact; ticks jitter by a cycle.
	assign sum = {1'b0, acc_q} + 12'(STEP);
	assign wrap = sum >= 12'(MODULUS);
	assign acc_d = wrap ? 11'(sum - 12'(MODULUS)) : sum[10:0];

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			acc_q <= 11'h000;
			tick_out <= 1'b0;
		end else begin
			acc_q <= acc_d;
			tick_out <= wrap;
		end
	end

endmodule

// >>> test/key_matrix_model.sv
`timescale 1ns/1ps
module key_matrix_model (
	input wire logic [3:0] row_scan_in,
	input wire logic direct_in,
	input wire logic [127:0] keys_in,
	output logic [7:0] col_n_out
);
	// Pull-ups keep idle columns high, so no stale level can pass for a key.
	always_comb begin
		col_n_out = 8'hFF;
		for (int r = 0; r < 16; r++) begin
			if (direct_in ? (r < 4 && !row_scan_in[r[1:0]]) :
					(row_scan_in == 4'(r))) begin
				col_n_out = col_n_out & ~keys_in[r * 8 +: 8];
			end
		end
	end
endmodule

// >>> test/keypad_sva.sv
`timescale 1ns/1ps
module keypad_sva
	import keypad_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [7:0] col_n_in,
	input wire logic powerdown_in,
	input wire logic [3:0] row_scan_out,
	input wire logic port_select_out,
	input wire logic key_irq_out,
	input wire logic chip_reset_out_n,
	input wire logic wake_out
);
	logic [1:0] size_q;
	logic scan_q;
	logic wake_q;
	logic [7:0] low_q;
	wire wr = psel_in && penable_in && pwrite_in;
	wire mapped = paddr_in inside {CONFIG_ADDR, THREE_KEY_ADDR, WAKE_ADDR,
		STATUS_ADDR};
	// Mirrors of the config fields, taken at the same edge as the design.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			size_q <= SIZE_4;
			scan_q <= 1'b0;
			wake_q <= 1'b0;
			low_q <= 8'h00;
		end else begin
			if (wr && paddr_in == CONFIG_ADDR) begin
				size_q <= pwdata_in[CFG_SIZE_LSB +: 2];
				scan_q <= pwdata_in[CFG_EN_BIT];
			end
			if (wr && paddr_in == WAKE_ADDR) begin
				wake_q <= pwdata_in[WK_EN_BIT];
			end
			low_q <= chip_reset_out_n ? 8'h00 : low_q + 8'h01;
		end
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	bus_ready_a: assert property (pready_out)
		else $error("pready low");
	unmapped_err_a: assert property (pslverr_out ==
		(psel_in && penable_in && !mapped)) else $error("pslverr wrong");
	port_sel_a: assert property (wr && paddr_in == CONFIG_ADDR |=> ##1
		port_select_out == $past(pwdata_in[CFG_SEL_BIT], 2))
		else $error("port select wrong");
	direct_rows_a: assert property ((size_q == SIZE_4) [*3] |->
		$countones(~row_scan_out) <= 1) else $error("rows not one-hot");
	rows_idle_a: assert property (
		(size_q == SIZE_4 && !scan_q && !powerdown_in) [*4] |->
		row_scan_out == 4'hF) else $error("rows active while off");
	pulse_bound_a: assert property (low_q <= RESET_PULSE_CYC)
		else $error("reset pulse too long");
	pulse_width_a: assert property ($rose(chip_reset_out_n) |->
		low_q == RESET_PULSE_CYC) else $error("reset pulse width");
	wake_gate_a: assert property (wake_out |->
		$past(size_q) == SIZE_4 && $past(wake_q)) else $error("wake ungated");
	irq_scan_a: assert property ($rose(key_irq_out) |-> scan_q)
		else $error("irq without scan");
	row_step_a: assert property (scan_q && $past(scan_q) &&
		size_q != SIZE_4 && $past(size_q) != SIZE_4 && !powerdown_in &&
		!$past(powerdown_in) && $changed(row_scan_out) |->
		row_scan_out == $past(row_scan_out) + 4'h1)
		else $error("row order wrong");
endmodule
bind keypad_matrix_scanner keypad_sva sva (.*);

// >>> test/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("[ERR] %s exp %h got %h", n, (e), (g)); \
	end \
end
module testbench
	import keypad_pkg::*;
;
	localparam logic [31:0] IRQ_F = 32'h0020_0000;
	localparam logic [31:0] RST_F = 32'h0010_0000;
	localparam logic [31:0] WK_F = 32'h0008_0000;
	localparam logic [31:0] CMB_F = 32'h0004_0000;
	localparam logic [31:0] TWO_F = 32'h0002_0000;
	localparam logic [31:0] ONE_F = 32'h0001_0000;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic powerdown_in = 1'b0;
	logic direct = 1'b1;
	logic [31:0] paddr_in = 32'h0;
	logic [31:0] pwdata_in = 32'h0;
	logic [127:0] keys = 128'h0;
	logic [127:0] three;
	logic [31:0] prdata_out, rd;
	logic pready_out, pslverr_out, port_select_out, key_irq_out, err;
	logic chip_reset_out_n, wake_out;
	logic [7:0] col_n_in;
	logic [3:0] row_scan_out;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int lat;
	wire [2:0] evt = {wake_out, ~chip_reset_out_n, key_irq_out};
	logic [31:0] regs [3] = '{CONFIG_ADDR, THREE_KEY_ADDR, WAKE_ADDR};
	logic [31:0] masks [3] = '{CONFIG_MASK, THREE_KEY_MASK, WAKE_MASK};
	always #5 ref_clk_in = ~ref_clk_in;
	keypad_matrix_scanner uut (.*);
	key_matrix_model model (.row_scan_in(row_scan_out), .direct_in(direct),
		.keys_in(keys), .col_n_out(col_n_in));
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 95000) begin
			errors++;
			test_done();
		end
	end
	task test_done();
		if (errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	function automatic logic [127:0] key(input int r, input int c);
		return 128'h1 << (r * 8 + c);
	endfunction
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge ref_clk_in);
		penable_in <= 1'b1;
		@(posedge ref_clk_in);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task wait_evt(input int b);
		lat = 0;
		while (evt[b] !== 1'b1 && lat < 20000) begin
			@(posedge ref_clk_in);
			lat++;
		end
		`CHK("event", 1'b1, evt[b])
	endtask
	// Every report is read back at once, so stale flags never leak onward.
	task step(input logic [127:0] k, input logic [31:0] e, input logic [31:0] m);
		@(posedge ref_clk_in);
		keys <= k;
		wait_evt(0);
		apb(1'b0, STATUS_ADDR, 32'h0);
		`CHK("status", e, rd & m)
		@(posedge ref_clk_in);
		@(posedge ref_clk_in);
		`CHK("irq", 1'b0, key_irq_out)
	endtask
	initial begin
		repeat (8) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, CONFIG_ADDR + 32'(4 * i), 32'h0);
			`CHK("reset", 32'h0, rd)
		end
		apb(1'b1, 32'hB800_8010, 32'hFFFF_FFFF);
		`CHK("slverr", 1'b1, err)
		apb(1'b0, 32'hB800_8010, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, regs[i], 32'hFFFF_FFFF);
			apb(1'b0, regs[i], 32'h0);
			`CHK("mask", masks[i], rd)
			apb(1'b1, regs[i], 32'h0);
		end
		apb(1'b1, STATUS_ADDR, 32'hFFFF_FFFF);
		apb(1'b0, STATUS_ADDR, 32'h0);
		`CHK("status ro", 32'h0, rd)
		// A debounce count of one hides the partial scan around a press.
		apb(1'b1, CONFIG_ADDR, 32'h000C_0101);
		step(key(2, 3), IRQ_F | ONE_F | 32'h13, '1);
		`CHK("port_select", 1'b1, port_select_out)
		apb(1'b0, STATUS_ADDR, 32'h0);
		`CHK("int clear", ONE_F | 32'h13, rd)
		step(128'h0, IRQ_F, 32'h0023_0000);
		apb(1'b1, CONFIG_ADDR, 32'h000D_0101);
		direct <= 1'b0;
		three = key(3, 6) | key(5, 1) | key(7, 0);
		step(three, IRQ_F | TWO_F | 32'h291E, '1);
		step(128'h0, IRQ_F, 32'h0023_0000);
		apb(1'b1, THREE_KEY_ADDR, 32'h0238_291E);
		step(three, IRQ_F | TWO_F | CMB_F | 32'h291E, '1);
		step(128'h0, IRQ_F, 32'h0023_0000);
		apb(1'b1, THREE_KEY_ADDR, 32'h0338_291E);
		@(posedge ref_clk_in);
		keys <= three;
		wait_evt(1);
		repeat (120) @(posedge ref_clk_in);
		apb(1'b0, STATUS_ADDR, 32'h0);
		`CHK("combo reset", RST_F, rd & RST_F)
		apb(1'b1, THREE_KEY_ADDR, 32'h0);
		step(128'h0, IRQ_F, 32'h0023_0000);
		apb(1'b1, CONFIG_ADDR, 32'h000F_0101);
		step(key(12, 5), IRQ_F | ONE_F | 32'h65, '1);
		step(128'h0, IRQ_F, 32'h0023_0000);
		apb(1'b1, CONFIG_ADDR, 32'h000C_0301);
		direct <= 1'b1;
		step(key(0, 0), IRQ_F | ONE_F, '1);
		`CHK("debounce", 1'b1, lat >= 6500 && lat < 8800)
		step(128'h0, IRQ_F, 32'h0023_0000);
		apb(1'b1, CONFIG_ADDR, 32'h0008_0000);
		apb(1'b1, WAKE_ADDR, 32'h0001_0801);
		powerdown_in <= 1'b1;
		keys <= key(1, 2);
		repeat (300) @(posedge ref_clk_in);
		`CHK("no wake", 1'b0, wake_out)
		keys <= key(1, 3);
		wait_evt(2);
		powerdown_in <= 1'b0;
		keys <= 128'h0;
		apb(1'b0, STATUS_ADDR, 32'h0);
		`CHK("wake flag", WK_F, rd & WK_F)
		apb(1'b1, CONFIG_ADDR, 32'h0009_0000);
		direct <= 1'b0;
		powerdown_in <= 1'b1;
		keys <= key(1, 3);
		repeat (300) @(posedge ref_clk_in);
		`CHK("size wake", 1'b0, wake_out)
		test_done();
	end
endmodule
